// [verilog/pcc_host.sv]
/*
 Host controller driving a flash card's parallel port in memory, I/O
 and True IDE modes. Assumes card pins are synchronous to clock.
*/
//
// Behaviour
// - IDE activity/slave-present line is two-way; host listens only.
// - outside IDE mode, host deems card inserted only when both detect inputs are low.
// - in IDE mode detect pins are ignored.
// - word access: even byte on D00-D07, odd byte on D08-D15; byte access always on D00-D07.
// - IDE task-file access byte-wide on low lane; data register 16 bits.
// - host makes I/O read strobe; bus not driven by host meanwhile.
// - memory mode writes and config writes use write-enable.
// - IDE mode holds write-enable high.
// - IDE mode holds output-enable low.
// - IDE uses A2:A0 only; higher address lines held low from the first IDE access on.
`timescale 1ns/1ps
module pcc_host
	import pcc_host_pkg::*;
(
	// clock and reset
	input  wire logic              clock,
	input  wire logic              resetn,
	// mode select
	input  wire logic [1:0]        mode,
	// command port
	input  wire logic              cmd_valid,
	output logic                   cmd_ready,
	input  wire logic              cmd_write,
	input  wire logic              cmd_cfg,
	input  wire logic              cmd_word,
	input  wire logic [ADDR_W-1:0] cmd_addr,
	input  wire logic [DATA_W-1:0] cmd_wdata,
	// read responses
	output logic                   rsp_valid,
	output logic [DATA_W-1:0]      rsp_data,
	input  wire logic              rsp_ready,
	// status
	output logic                   card_present,
	output logic                   aux_status_high,
	output logic                   drive_active,
	// card pins
	output logic [ADDR_W-1:0]      addr,
	input  wire logic [DATA_W-1:0] data_in,
	output logic [DATA_W-1:0]      data_out,
	output logic                   data_oe,
	output logic                   ce1_n,
	output logic                   ce2_n,
	output logic                   reg_n,
	output logic                   oe_n,
	output logic                   we_n,
	output logic                   iord_n,
	output logic                   iowr_n,
	input  wire logic              cd1_n,
	input  wire logic              cd2_n,
	input  wire logic              bvd2_in,
	input  wire logic              dasp_n_in,
	output logic                   dasp_n_out,
	output logic                   dasp_oe
);
	typedef struct packed {
		state_t              st;
		logic [CNT_W-1:0]    cnt;
		logic [1:0]          mode;
		strobe_t             sb;
		logic                write;
		logic                word;
		logic [ADDR_W-1:0]   addr;
		logic [DATA_W-1:0]   dout;
		logic                doe;
		logic                ce1_n;
		logic                ce2_n;
		logic                reg_n;
		logic                oe_n;
		logic                we_n;
		logic                iord_n;
		logic                iowr_n;
		logic                cmd_ready;
		logic [DATA_W-1:0]   rdata;
		logic                push;
		logic                present;
		logic                aux_hi;
		logic                dasp_act;
	} host_t;

	// strobe choice for an access
	function automatic strobe_t pick(input logic [1:0] m, input logic wr, input logic cfg);
		if (m == MODE_IDE || (m == MODE_IO && !cfg))
			pick = wr ? SB_IOWR : SB_IORD;
		else
			pick = wr ? SB_WE : SB_OE;
	endfunction

	logic [1:0] rst_sync_q;
	logic       sys_rst_n;
	host_t      s_q;
	host_t      s_d;
	logic       accept;
	logic       ide;
	logic       buf_ready;

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			rst_sync_q <= 2'h0;
		else
			rst_sync_q <= {rst_sync_q[0], 1'b1};
	end
	assign sys_rst_n = rst_sync_q[1];

	always_comb
	begin
		s_d      = s_q;
		s_d.push = 1'b0;
		accept   = cmd_valid && s_q.cmd_ready;
		ide      = (mode == MODE_IDE);
		case (s_q.st)
			ST_IDLE:
			begin
				s_d.mode = mode;
				if (accept)
				begin
					s_d.write = cmd_write;
					s_d.sb    = pick(mode, cmd_write, cmd_cfg);
					s_d.word  = ide ? (cmd_addr[TF_SEL_W-1:0] == TF_DATA_REG) : cmd_word;
					s_d.addr  = ide ? {{(ADDR_W-TF_SEL_W){1'b0}}, cmd_addr[TF_SEL_W-1:0]}
						: cmd_addr;
					s_d.reg_n = ide || !cmd_cfg;
					s_d.ce1_n = 1'b0;
					s_d.ce2_n = ide || !s_d.word;
					s_d.dout  = s_d.word ? cmd_wdata
						: {BYTE_ZERO, cmd_wdata[BYTE_W-1:0]};
					s_d.doe   = cmd_write;
					s_d.cnt   = SETUP_CYC;
					s_d.st    = ST_SETUP;
				end
			end
			ST_SETUP:
			begin
				if (s_q.cnt == CNT_ONE)
				begin
					case (s_q.sb)
						SB_OE:   s_d.oe_n = 1'b0;
						SB_WE:   s_d.we_n = 1'b0;
						SB_IORD: s_d.iord_n = 1'b0;
						SB_IOWR: s_d.iowr_n = 1'b0;
						default: s_d.oe_n = 1'b1;
					endcase
					s_d.cnt = STROBE_CYC;
					s_d.st  = ST_STROBE;
				end
				else
					s_d.cnt = s_q.cnt - CNT_ONE;
			end
			ST_STROBE:
			begin
				if (s_q.cnt == CNT_ONE)
				begin
					s_d.oe_n   = 1'b1;
					s_d.we_n   = 1'b1;
					s_d.iord_n = 1'b1;
					s_d.iowr_n = 1'b1; // data still driven through hold
					if (!s_q.write)
					begin
						s_d.rdata = s_q.word ? data_in
							: {BYTE_ZERO, data_in[BYTE_W-1:0]};
						s_d.push  = 1'b1;
					end
					s_d.cnt = HOLD_CYC;
					s_d.st  = ST_HOLD;
				end
				else
					s_d.cnt = s_q.cnt - CNT_ONE;
			end
			ST_HOLD:
			begin
				if (s_q.cnt == CNT_ONE)
				begin
					s_d.doe   = 1'b0;
					s_d.ce1_n = 1'b1;
					s_d.ce2_n = 1'b1;
					s_d.reg_n = 1'b1;
					s_d.st    = ST_IDLE;
				end
				else
					s_d.cnt = s_q.cnt - CNT_ONE;
			end
			default:
				s_d.st = ST_IDLE;
		endcase
		if (s_d.mode == MODE_IDE)
		begin
			s_d.oe_n = 1'b0;
			s_d.we_n = 1'b1;
		end
		else if (s_q.st == ST_IDLE)
			s_d.oe_n = 1'b1;
		s_d.cmd_ready = (s_d.st == ST_IDLE) && buf_ready && !s_d.push && !s_q.push;
		s_d.present   = ide || (!cd1_n && !cd2_n);
		s_d.aux_hi    = !ide && bvd2_in;
		s_d.dasp_act  = ide && !dasp_n_in;
	end

	always_ff @(posedge clock or negedge sys_rst_n)
	begin
		if (!sys_rst_n)
		begin
			s_q        <= '0;
			s_q.st     <= ST_IDLE;
			s_q.ce1_n  <= 1'b1;
			s_q.ce2_n  <= 1'b1;
			s_q.reg_n  <= 1'b1;
			s_q.oe_n   <= 1'b1;
			s_q.we_n   <= 1'b1;
			s_q.iord_n <= 1'b1;
			s_q.iowr_n <= 1'b1;
		end
		else
			s_q <= s_d;
	end

	pcc_rsp_buffer #(
		.WIDTH (DATA_W),
		.DEPTH (BUF_DEPTH)
	) u_rsp_buffer (
		.clock     (clock),
		.rst_n     (sys_rst_n),
		.in_valid  (s_q.push),
		.in_data   (s_q.rdata),
		.in_ready  (buf_ready),
		.out_valid (rsp_valid),
		.out_data  (rsp_data),
		.out_ready (rsp_ready)
	);

	assign cmd_ready       = s_q.cmd_ready;
	assign card_present    = s_q.present;
	assign aux_status_high = s_q.aux_hi;
	assign drive_active    = s_q.dasp_act;
	assign addr            = s_q.addr;
	assign data_out        = s_q.dout;
	assign data_oe         = s_q.doe;
	assign ce1_n           = s_q.ce1_n;
	assign ce2_n           = s_q.ce2_n;
	assign reg_n           = s_q.reg_n;
	assign oe_n            = s_q.oe_n;
	assign we_n            = s_q.we_n;
	assign iord_n          = s_q.iord_n;
	assign iowr_n          = s_q.iowr_n;
	assign dasp_n_out      = 1'b1;
	assign dasp_oe         = 1'b0;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!sys_rst_n);

	sequence s_read_accept;
		cmd_valid && cmd_ready && !cmd_write;
	endsequence
	sequence s_iowr_release;
		$rose(iowr_n);
	endsequence

	AST_IDE_WE_HIGH: assert property (s_q.mode == MODE_IDE |-> we_n)
		else $error("write-enable low in IDE mode");
	AST_IDE_OE_LOW: assert property (s_q.mode == MODE_IDE |-> !oe_n)
		else $error("output-enable high in IDE mode");
	AST_IDE_ADDR_HI: assert property (s_q.mode == MODE_IDE && s_q.st != ST_IDLE
		|-> addr[ADDR_W-1:TF_SEL_W] == '0)
		else $error("upper address set in IDE mode");
	AST_NO_DRIVE_READ: assert property (!iord_n || (!oe_n && s_q.mode != MODE_IDE)
		|-> !data_oe)
		else $error("host drives bus during read strobe");
	AST_WRITE_HELD: assert property (s_iowr_release |-> data_oe && $stable(data_out))
		else $error("write data not held at strobe release");
	AST_MEM_NO_IO: assert property (s_q.mode == MODE_MEM |-> iord_n && iowr_n)
		else $error("I/O strobe used in memory mode");
	AST_BYTE_LANE: assert property (data_oe && !s_q.word |-> data_out[DATA_W-1:BYTE_W] == '0)
		else $error("byte write leaks onto high lane");
	AST_PRESENT: assert property (mode != MODE_IDE && (cd1_n || cd2_n) |=> !card_present)
		else $error("card reported present with a detect pin high");
	AST_IDE_PRESENT: assert property (mode == MODE_IDE |=> card_present)
		else $error("IDE presence depends on detect pins");
	AST_READ_PUSH: assert property (s_read_accept |-> ##[1:30] s_q.push)
		else $error("read not answered in time");
	AST_IO_STROBE_IDE: assert property (s_q.mode == MODE_IDE && s_q.st == ST_STROBE
		|-> !iord_n || !iowr_n)
		else $error("IDE access without I/O strobe");
endmodule

// [verilog/pcc_host_pkg.sv]
/*
 Shared constants and types for the card host controller.
 Assumes a 40 MHz system clock.
*/
package pcc_host_pkg;
	localparam int ADDR_W        = 11;
	localparam int DATA_W        = 16;
	localparam int BYTE_W        = 8;
	localparam int TF_SEL_W      = 3;
	localparam int BUF_DEPTH     = 2;
	localparam int CNT_W         = 4;
	localparam int CLK_PERIOD_NS = 25;
	localparam int T_SETUP_NS    = 30;
	localparam int T_STROBE_NS   = 165;
	localparam int T_HOLD_NS     = 20;

	localparam logic [TF_SEL_W-1:0] TF_DATA_REG = 3'h0;
	localparam logic [BYTE_W-1:0]   BYTE_ZERO   = 8'h00;
	localparam logic [CNT_W-1:0]    CNT_ONE     = 4'h1;

	// least times: round up, never below one cycle
	function automatic logic [CNT_W-1:0] cyc(input int t_ns);
		int c;
		c = (t_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		if (c < 1)
			c = 1;
		cyc = CNT_W'(c);
	endfunction

	localparam logic [CNT_W-1:0] SETUP_CYC  = cyc(T_SETUP_NS);
	localparam logic [CNT_W-1:0] STROBE_CYC = cyc(T_STROBE_NS);
	localparam logic [CNT_W-1:0] HOLD_CYC   = cyc(T_HOLD_NS);

	typedef enum logic [1:0] {
		MODE_MEM = 2'h0,
		MODE_IO  = 2'h1,
		MODE_IDE = 2'h2
	} mode_t;

	typedef enum logic [1:0] {
		ST_IDLE   = 2'h0,
		ST_SETUP  = 2'h1,
		ST_STROBE = 2'h2,
		ST_HOLD   = 2'h3
	} state_t;

	typedef enum logic [1:0] {
		SB_OE   = 2'h0,
		SB_WE   = 2'h1,
		SB_IORD = 2'h2,
		SB_IOWR = 2'h3
	} strobe_t;
endpackage

// [verilog/pcc_rsp_buffer.sv]
/*
 Shift-register response buffer with valid/ready on both sides.
 Assumes rst_n asserts asynchronously and is released in step with clock.
*/
`timescale 1ns/1ps
module pcc_rsp_buffer #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 2
) (
	// clock and reset
	input  wire logic             clock,
	input  wire logic             rst_n,
	// fill side
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  in_ready,
	// drain side
	output logic                  out_valid,
	output logic [WIDTH-1:0]      out_data,
	input  wire logic             out_ready
);
	localparam int CW = $clog2(DEPTH + 1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [CW-1:0]               cnt;
		logic                        ovalid;
		logic                        iready;
	} buf_t;

	buf_t          s_q;
	buf_t          s_d;
	logic          pop;
	logic          push;
	logic [CW-1:0] c;

	always_comb
	begin
		s_d  = s_q;
		pop  = s_q.ovalid && out_ready;
		push = in_valid && s_q.iready;
		c    = s_q.cnt;
		if (pop)
		begin
			for (int i = 0; i < DEPTH - 1; i++)
				s_d.mem[i] = s_q.mem[i+1];
			c = c - 1'b1;
		end
		if (push)
		begin
			for (int i = 0; i < DEPTH; i++)
				if (CW'(i) == c)
					s_d.mem[i] = in_data;
			c = c + 1'b1;
		end
		s_d.cnt    = c;
		s_d.ovalid = (c != '0);
		s_d.iready = (c != CW'(DEPTH));
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_q        <= '0;
			s_q.iready <= 1'b1;
		end
		else
			s_q <= s_d;
	end

	assign in_ready  = s_q.iready;
	assign out_valid = s_q.ovalid;
	assign out_data  = s_q.mem[0];
endmodule

// [dv/pcc_card_model.sv]
/*
 Behavioural card on the far side of the host controller.
 Assumes the bench resolves the shared data bus from both enables.
*/
`timescale 1ns/1ps
module pcc_card_model
	import pcc_host_pkg::*;
(
	// host pins
	input  wire logic [1:0]        mode,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [DATA_W-1:0] bus,
	input  wire logic              ce1_n,
	input  wire logic              oe_n,
	input  wire logic              we_n,
	input  wire logic              iord_n,
	input  wire logic              iowr_n,
	// card outputs
	output logic [DATA_W-1:0]      card_d,
	output logic                   card_oe,
	output logic                   bvd2,
	output logic                   cd1_n,
	output logic                   cd2_n,
	output int                     we_cnt
);
	logic [DATA_W-1:0] mem [8];

	assign bvd2    = 1'b1;
	assign cd1_n   = 1'b0;
	assign cd2_n   = 1'b0;
	assign card_oe = (mode != MODE_IDE && !oe_n && !ce1_n)
		|| (mode != MODE_MEM && !iord_n);
	assign card_d  = mem[addr[2:0]];
	initial we_cnt = 0;
	always @(posedge iowr_n)
		if (mode != MODE_MEM)
			mem[addr[2:0]] = bus;
	always @(posedge we_n)
		if (mode != MODE_IDE)
		begin
			we_cnt++;
			mem[addr[2:0]] = bus;
		end
endmodule

// [dv/test_pcc_host.sv]
/*
 Self-checking bench for the card host controller.
 Assumes the behavioural card model stands on the card pins.
*/
`timescale 1ns/1ps
module test_pcc_host;
	import pcc_host_pkg::*;
	// drive
	logic              clock = 0;
	logic              resetn = 0;
	logic [1:0]        mode = MODE_MEM;
	logic              cmd_valid = 0;
	logic              cmd_write = 0;
	logic              cmd_cfg = 0;
	logic              cmd_word = 0;
	logic [ADDR_W-1:0] cmd_addr = '0;
	logic [DATA_W-1:0] cmd_wdata = '0;
	logic              rsp_ready = 0;
	logic              dasp_n = 1;
	logic              lift = 0;
	logic              ide_chk = 0;
	// observe
	logic              cmd_ready, rsp_valid, card_present, aux_status_high, drive_active;
	logic [DATA_W-1:0] rsp_data, data_out, data_in, card_d;
	logic [DATA_W-1:0] last_bus = '0;
	logic [ADDR_W-1:0] addr;
	logic              data_oe, ce1_n, ce2_n, reg_n, oe_n, we_n, iord_n, iowr_n;
	logic              dasp_n_out, dasp_oe, card_oe, bvd2, cd1_n, cd2_n;
	int                we_cnt, cnt, error_cnt = 0, cmp_count = 0, cycles = 0;
	// pin levels seen during the latest strobe
	logic              seen_ce2_n = 1, seen_reg_n = 1;

	always #12.5 clock = ~clock;
	// released bus shows the inverse of its last level
	assign data_in = data_oe ? data_out : (card_oe ? card_d : ~last_bus);
	always @(posedge clock) last_bus <= data_in;

	pcc_host uut (.clock(clock), .resetn(resetn), .mode(mode), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .cmd_write(cmd_write), .cmd_cfg(cmd_cfg), .cmd_word(cmd_word),
		.cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
		.rsp_ready(rsp_ready), .card_present(card_present), .aux_status_high(aux_status_high),
		.drive_active(drive_active), .addr(addr), .data_in(data_in), .data_out(data_out),
		.data_oe(data_oe), .ce1_n(ce1_n), .ce2_n(ce2_n), .reg_n(reg_n), .oe_n(oe_n),
		.we_n(we_n), .iord_n(iord_n), .iowr_n(iowr_n), .cd1_n(cd1_n), .cd2_n(cd2_n | lift),
		.bvd2_in(bvd2), .dasp_n_in(dasp_oe ? dasp_n_out : dasp_n), .dasp_n_out(dasp_n_out),
		.dasp_oe(dasp_oe));

	pcc_card_model card (.mode(mode), .addr(addr), .bus(data_in), .ce1_n(ce1_n), .oe_n(oe_n),
		.we_n(we_n), .iord_n(iord_n), .iowr_n(iowr_n), .card_d(card_d), .card_oe(card_oe),
		.bvd2(bvd2), .cd1_n(cd1_n), .cd2_n(cd2_n), .we_cnt(we_cnt));

	task automatic wrap_up;
		if (error_cnt == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic chk_bit(input logic got, input logic exp, input string msg);
		cmp_count++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("ERROR %0t %s", $time, msg);
		end
	endtask

	task automatic chk_word(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("ERROR %0t read %h expected %h", $time, got, exp);
		end
	endtask

	task automatic put(input logic w, c, wd, input logic [10:0] a, input logic [15:0] d);
		@(negedge clock);
		{cmd_write, cmd_cfg, cmd_word, cmd_addr, cmd_wdata} = {w, c, wd, a, d};
		cmd_valid = 1;
	endtask

	task automatic take;
		while (cmd_ready !== 1'b1) @(negedge clock);
		@(negedge clock);
		cmd_valid = 0;
	endtask

	task automatic get(input logic [DATA_W-1:0] exp);
		@(negedge clock);
		while (rsp_valid !== 1'b1) @(negedge clock);
		chk_word(rsp_data, exp);
		rsp_ready = 1;
		@(negedge clock);
		rsp_ready = 0;
	endtask

	task automatic set_mode(input logic [1:0] m);
		@(negedge clock);
		while (cmd_ready !== 1'b1) @(negedge clock);
		mode = m;
		repeat (3) @(negedge clock);
	endtask

	task automatic t_status;
		set_mode(MODE_MEM);
		chk_bit(card_present, 1'b1, "card absent");
		chk_bit(aux_status_high, 1'b1, "battery line low");
		lift = 1;
		repeat (2) @(negedge clock);
		chk_bit(card_present, 1'b0, "half-inserted card present");
		set_mode(2'h3);
		chk_bit(card_present, 1'b0, "detect ignored in mode 3");
		set_mode(MODE_IO);
		chk_bit(aux_status_high, 1'b1, "speaker line low");
		set_mode(MODE_IDE);
		chk_bit(card_present, 1'b1, "detect used in ide");
		dasp_n = 0;
		repeat (2) @(negedge clock);
		chk_bit(drive_active, 1'b1, "activity missed");
		chk_bit(dasp_oe, 1'b0, "activity line driven");
		chk_bit(dasp_n_out, 1'b1, "activity line pulled low");
		dasp_n = 1;
		lift = 0;
		repeat (2) @(negedge clock);
		chk_bit(drive_active, 1'b0, "activity stuck");
	endtask

	task automatic t_mem;
		set_mode(MODE_MEM);
		cnt = we_cnt;
		put(1, 0, 1, 11'h005, 16'hBEEF); take;
		put(0, 0, 1, 11'h005, 16'h0000); take;
		get(16'hBEEF);
		chk_bit(seen_ce2_n, 1'b0, "word access without high lane");
		chk_bit(seen_reg_n, 1'b1, "common access in attribute space");
		chk_bit(we_cnt == cnt + 1, 1'b1, "write strobe count");
		put(0, 0, 0, 11'h005, 16'h0000); take;
		get(16'h00EF);
		chk_bit(seen_ce2_n, 1'b1, "byte access enabled high lane");
	endtask

	task automatic t_io;
		set_mode(MODE_IO);
		cnt = we_cnt;
		put(1, 0, 1, 11'h002, 16'h1234); take;
		put(0, 0, 1, 11'h002, 16'h0000); take;
		get(16'h1234);
		chk_bit(we_cnt == cnt, 1'b1, "write enable on io write");
		put(1, 1, 0, 11'h003, 16'h0055); take;
		set_mode(MODE_IO);
		chk_bit(we_cnt == cnt + 1, 1'b1, "config write missed");
		chk_bit(seen_reg_n, 1'b0, "config write outside attribute space");
		put(0, 1, 0, 11'h003, 16'h0000); take;
		get(16'h0055);
		chk_bit(we_cnt == cnt + 1, 1'b1, "write enable on config read");
	endtask

	task automatic t_ide;
		set_mode(MODE_IDE);
		ide_chk = 1;
		put(1, 0, 0, 11'h000, 16'hCAFE); take;
		put(0, 0, 0, 11'h000, 16'h0000); take;
		get(16'hCAFE);
		put(1, 0, 1, 11'h7FB, 16'h775A); take;
		put(0, 0, 1, 11'h003, 16'h0000); take;
		get(16'h005A);
		chk_bit(seen_ce2_n, 1'b1, "task-file access enabled high lane");
		set_mode(MODE_IDE);
		ide_chk = 0;
	endtask

	task automatic t_buf;
		set_mode(MODE_MEM);
		put(1, 0, 1, 11'h001, 16'h1111); take;
		put(1, 0, 1, 11'h002, 16'h2222); take;
		put(0, 0, 1, 11'h001, 16'h0000); take;
		put(0, 0, 1, 11'h002, 16'h0000); take;
		put(0, 0, 1, 11'h005, 16'h0000);
		repeat (30) @(negedge clock);
		chk_bit(cmd_ready, 1'b0, "full buffer took a read");
		get(16'h1111);
		take;
		get(16'h2222);
		get(16'hBEEF);
	endtask

	always @(negedge clock)
	begin
		if (resetn && mode == MODE_MEM)
			chk_bit(iord_n & iowr_n, 1'b1, "io strobe in memory mode");
		if (ide_chk)
			chk_bit(we_n & ~oe_n & ~|addr[10:3], 1'b1, "ide pin levels");
		chk_bit(data_oe & card_oe, 1'b0, "bus contention");
		if (!we_n || !iord_n || !iowr_n)
			chk_bit(ce1_n, 1'b0, "strobe without card enable");
		if (!we_n || !iord_n || !iowr_n || (!oe_n && !ce1_n && mode != MODE_IDE))
		begin
			seen_ce2_n = ce2_n;
			seen_reg_n = reg_n;
		end
	end

	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			error_cnt++;
			wrap_up;
		end
	end

	initial
	begin
		repeat (8) @(negedge clock);
		resetn = 1;
		t_status;
		t_mem;
		t_io;
		t_ide;
		t_buf;
		wrap_up;
	end
endmodule
